/* File: rtl/icia_iso_ctx_irq.sv */
// Notes on behaviour
// - each of eight contexts per direction interrupts
// - writing one to mask enables that context
// - one summary bit per direction
// - per-context event registers are readable
// - all-ones mask reads back implemented bits only
// - four to thirty-two contexts, here eight
// - mismatch leaves ordinary contexts running
// - mismatch holds start-on-cycle contexts inactive
// - eight transmit control registers, set and clear
// - every context has control and pointer
// - clear-port ones clear the main mismatch event only; the summary bits follow the banks
// - event code field is five bits
`timescale 1ns/1ps
module icia_iso_ctx_irq #(
  parameter int N_CTX = icia_pkg::ISO_CTX_NUM
) (
  // clock and reset
  input logic clk_sys,
  input logic rst_n,
  // host register port
  input logic reg_wr,
  input logic reg_rd,
  input logic [11:0] reg_addr,
  input logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // transmit dma engines
  input logic [N_CTX-1:0] it_irq_req,
  input logic [N_CTX-1:0] it_dma_active,
  input logic [N_CTX-1:0] it_dma_dead,
  input logic [N_CTX-1:0] it_evt_we,
  input logic [N_CTX*5-1:0] it_evt_code,
  output logic [N_CTX-1:0] it_run_gate,
  output logic [N_CTX-1:0] it_start,
  output logic [N_CTX-1:0] it_wake,
  // receive dma engines
  input logic [N_CTX-1:0] ir_irq_req,
  input logic [N_CTX-1:0] ir_dma_active,
  input logic [N_CTX-1:0] ir_dma_dead,
  input logic [N_CTX-1:0] ir_evt_we,
  input logic [N_CTX*5-1:0] ir_evt_code,
  output logic [N_CTX-1:0] ir_run_gate,
  output logic [N_CTX-1:0] ir_start,
  output logic [N_CTX-1:0] ir_wake,
  // cycle timer
  input logic [14:0] cycle_now,
  input logic cycle_incons_pulse,
  // summary state
  output logic xmit_summary_bit,
  output logic recv_summary_bit,
  output logic cycle_timer_mismatch_event
);
  typedef struct packed {
    logic incons;       // mismatch pending
    logic tx_sum;       // transmit summary
    logic rx_sum;       // receive summary
    logic [31:0] rdata; // read answer
    logic rvalid;       // read answer valid
  } icia_top_state_t;

  icia_top_state_t st_reg;
  icia_top_state_t st_next;

  // bank outputs
  logic [N_CTX-1:0] xmit_ctx_event_reg;
  logic [N_CTX-1:0] xmit_ctx_mask_reg;
  logic [N_CTX-1:0] recv_ctx_event_reg;
  logic [N_CTX-1:0] recv_ctx_mask_reg;
  logic tx_any;
  logic rx_any;
  logic itc_hit;
  logic irc_hit;
  logic [31:0] itc_data;
  logic [31:0] irc_data;

  // zero-extend a context vector to a word
  function automatic logic [31:0] zext(input logic [N_CTX-1:0] v);
    logic [31:0] r;
    r = '0;
    r[N_CTX-1:0] = v;
    return r;
  endfunction : zext

  // bits that exist in a context vector
  localparam logic [31:0] IMPL_MASK = zext({N_CTX{1'b1}});

  // writes fan out to every bank
  icia_bus_if bus ();
  assign bus.wr = reg_wr;
  assign bus.addr = reg_addr;
  assign bus.wdata = reg_wdata;

  icia_event_bank #(
    .N(N_CTX),
    .EV_SET(icia_pkg::OFS_ITEV_SET),
    .EV_CLR(icia_pkg::OFS_ITEV_CLR),
    .MK_SET(icia_pkg::OFS_ITMSK_SET),
    .MK_CLR(icia_pkg::OFS_ITMSK_CLR)
  ) u_it_evt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(bus.bank),
    .ctx_irq(it_irq_req),
    .evt(xmit_ctx_event_reg),
    .msk(xmit_ctx_mask_reg),
    .summary(tx_any)
  );

  icia_event_bank #(
    .N(N_CTX),
    .EV_SET(icia_pkg::OFS_IREV_SET),
    .EV_CLR(icia_pkg::OFS_IREV_CLR),
    .MK_SET(icia_pkg::OFS_IRMSK_SET),
    .MK_CLR(icia_pkg::OFS_IRMSK_CLR)
  ) u_ir_evt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(bus.bank),
    .ctx_irq(ir_irq_req),
    .evt(recv_ctx_event_reg),
    .msk(recv_ctx_mask_reg),
    .summary(rx_any)
  );

  icia_ctx_bank #(
    .N(N_CTX),
    .BASE(icia_pkg::OFS_ITCTX_BASE),
    .IS_RX(1'b0)
  ) u_it_ctx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(bus.bank),
    .rd_addr(reg_addr),
    .rd_hit(itc_hit),
    .rd_data(itc_data),
    .cycle_now(cycle_now),
    .incons(st_reg.incons),
    .dma_active(it_dma_active),
    .dma_dead(it_dma_dead),
    .evt_we(it_evt_we),
    .evt_code(it_evt_code),
    .run_gate(it_run_gate),
    .start_pulse(it_start),
    .wake_pulse(it_wake)
  );

  // receive contexts carry the same pair
  icia_ctx_bank #(
    .N(N_CTX),
    .BASE(icia_pkg::OFS_IRCTX_BASE),
    .IS_RX(1'b1)
  ) u_ir_ctx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(bus.bank),
    .rd_addr(reg_addr),
    .rd_hit(irc_hit),
    .rd_data(irc_data),
    .cycle_now(cycle_now),
    .incons(st_reg.incons),
    .dma_active(ir_dma_active),
    .dma_dead(ir_dma_dead),
    .evt_we(ir_evt_we),
    .evt_code(ir_evt_code),
    .run_gate(ir_run_gate),
    .start_pulse(ir_start),
    .wake_pulse(ir_wake)
  );

  // main event bits and the read answer
  always_comb begin
    logic clr_hit;
    logic set_hit;
    clr_hit = reg_wr && reg_addr == icia_pkg::OFS_IEV_CLR;
    set_hit = reg_wr && reg_addr == icia_pkg::OFS_IEV_SET;
    st_next = st_reg;
    // summaries track the banks one cycle later
    st_next.tx_sum = tx_any;
    st_next.rx_sum = rx_any;
    // clear port drops the pending mismatch
    // the hardware event still wins the same cycle
    st_next.incons = (st_reg.incons
                      & ~(clr_hit & reg_wdata[icia_pkg::IEV_INCONS_BIT]))
                     | (set_hit & reg_wdata[icia_pkg::IEV_INCONS_BIT])
                     | cycle_incons_pulse;
    // reads answer one cycle after the strobe
    st_next.rvalid = reg_rd;
    st_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        // both main ports read the same word
        icia_pkg::OFS_IEV_SET, icia_pkg::OFS_IEV_CLR: begin
          st_next.rdata[icia_pkg::IEV_TX_BIT] = st_reg.tx_sum;
          st_next.rdata[icia_pkg::IEV_RX_BIT] = st_reg.rx_sum;
          st_next.rdata[icia_pkg::IEV_INCONS_BIT] = st_reg.incons;
        end
        icia_pkg::OFS_ITEV_SET, icia_pkg::OFS_ITEV_CLR: begin
          st_next.rdata = zext(xmit_ctx_event_reg);
        end
        icia_pkg::OFS_IREV_SET, icia_pkg::OFS_IREV_CLR: begin
          st_next.rdata = zext(recv_ctx_event_reg);
        end
        icia_pkg::OFS_ITMSK_SET, icia_pkg::OFS_ITMSK_CLR: begin
          st_next.rdata = zext(xmit_ctx_mask_reg);
        end
        icia_pkg::OFS_IRMSK_SET, icia_pkg::OFS_IRMSK_CLR: begin
          st_next.rdata = zext(recv_ctx_mask_reg);
        end
        // context banks, else unmapped reads zero
        default: begin
          if (itc_hit) begin
            st_next.rdata = itc_data;
          end else if (irc_hit) begin
            st_next.rdata = irc_data;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata = st_reg.rdata;
  assign reg_rvalid = st_reg.rvalid;
  assign xmit_summary_bit = st_reg.tx_sum;
  assign recv_summary_bit = st_reg.rx_sum;
  assign cycle_timer_mismatch_event = st_reg.incons;

  // the context count stays inside the permitted span
  a_ctx_count_range: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (N_CTX >= icia_pkg::CTX_MIN && N_CTX <= icia_pkg::CTX_MAX))
    else $error("context count out of range");
  // mask reads never show unimplemented contexts
  a_mask_read_high: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && (reg_addr == icia_pkg::OFS_ITMSK_SET
                || reg_addr == icia_pkg::OFS_IRMSK_SET))
    |=> ((reg_rdata & ~IMPL_MASK) == 32'h0000_0000))
    else $error("mask read shows missing context");
  // a new unmasked event reaches the summary in two edges
  a_summary_rise: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (|(it_irq_req & xmit_ctx_mask_reg)) |-> ##2 xmit_summary_bit)
    else $error("transmit summary missed");
  // summary follows the banks with one edge of lag
  a_summary_follow: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ##1 (recv_summary_bit == $past(|(recv_ctx_event_reg
                                      & recv_ctx_mask_reg))))
    else $error("receive summary mismatch");
  // clear with no new event drops the mismatch
  a_incons_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && reg_addr == icia_pkg::OFS_IEV_CLR
     && reg_wdata[icia_pkg::IEV_INCONS_BIT] && !cycle_incons_pulse)
    |=> !cycle_timer_mismatch_event)
    else $error("mismatch not cleared");
  // a mismatch stays until cleared
  a_incons_sticky: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cycle_incons_pulse |=> cycle_timer_mismatch_event
    ##1 (cycle_timer_mismatch_event || $past(reg_wr)))
    else $error("mismatch lost");
  // every read answers exactly one edge later
  a_read_answer: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
    else $error("read answer timing wrong");
  // event ports leave masks alone
  a_event_no_mask: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && reg_addr == icia_pkg::OFS_ITEV_CLR)
    |=> $stable(xmit_ctx_mask_reg))
    else $error("mask moved on event write");
endmodule : icia_iso_ctx_irq

/* File: rtl/icia_pkg.sv */
package icia_pkg;
  // contexts per direction and the permitted range
  localparam int ISO_CTX_NUM = 8;
  localparam int CTX_MIN = 4;
  localparam int CTX_MAX = 32;
  localparam int ADDR_W = 12;
  // main event register, read at either port
  localparam logic [11:0] OFS_IEV_SET = 12'h080;
  localparam logic [11:0] OFS_IEV_CLR = 12'h084;
  // per-context event and mask set/clear ports
  localparam logic [11:0] OFS_ITEV_SET = 12'h090;
  localparam logic [11:0] OFS_ITEV_CLR = 12'h094;
  localparam logic [11:0] OFS_ITMSK_SET = 12'h098;
  localparam logic [11:0] OFS_ITMSK_CLR = 12'h09c;
  localparam logic [11:0] OFS_IREV_SET = 12'h0a0;
  localparam logic [11:0] OFS_IREV_CLR = 12'h0a4;
  localparam logic [11:0] OFS_IRMSK_SET = 12'h0a8;
  localparam logic [11:0] OFS_IRMSK_CLR = 12'h0ac;
  // context control banks, one 16-byte slot per context
  localparam logic [11:0] OFS_ITCTX_BASE = 12'h200;
  localparam logic [11:0] OFS_IRCTX_BASE = 12'h400;
  localparam logic [3:0] CTX_SUB_SET = 4'h0;
  localparam logic [3:0] CTX_SUB_CLR = 4'h4;
  localparam logic [3:0] CTX_SUB_CPTR = 4'hc;
  // main event bit positions
  localparam int IEV_TX_BIT = 6;
  localparam int IEV_RX_BIT = 7;
  localparam int IEV_INCONS_BIT = 23;
  // context control field positions
  localparam int CTL_CME_TX_BIT = 31;
  localparam int CTL_CME_RX_BIT = 29;
  localparam int CTL_MATCH_LSB = 16;
  localparam int CTL_MATCH_W = 15;
  localparam int CTL_RUN_BIT = 15;
  localparam int CTL_WAKE_BIT = 12;
  localparam int CTL_DEAD_BIT = 11;
  localparam int CTL_ACTIVE_BIT = 10;
  localparam int CTL_EVT_W = 5;
  // values after reset
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : icia_pkg

/* File: rtl/icia_bus_if.sv */
`timescale 1ns/1ps
// register write strobe shared by the banks
interface icia_bus_if;
  logic wr;
  logic [11:0] addr;
  logic [31:0] wdata;
  // the top drives, the banks listen
  modport host (output wr, output addr, output wdata);
  modport bank (input wr, input addr, input wdata);
endinterface : icia_bus_if

/* File: rtl/icia_event_bank.sv */
`timescale 1ns/1ps
// per-context event and mask bits for one direction
module icia_event_bank #(
  parameter int N = 8,
  parameter logic [11:0] EV_SET = 12'h000,
  parameter logic [11:0] EV_CLR = 12'h004,
  parameter logic [11:0] MK_SET = 12'h008,
  parameter logic [11:0] MK_CLR = 12'h00c
) (
  // clock and reset
  input logic clk_sys,
  input logic rst_n,
  // register writes
  icia_bus_if.bank bus,
  // requests from the dma engines, one-cycle pulses
  input logic [N-1:0] ctx_irq,
  // state seen by the top
  output logic [N-1:0] evt,
  output logic [N-1:0] msk,
  output logic summary
);
  typedef struct packed {
    logic [N-1:0] evt; // sticky context events
    logic [N-1:0] msk; // context enables
  } icia_evb_state_t;

  icia_evb_state_t st_reg;
  icia_evb_state_t st_next;

  // ones in the data at a hit port, else nothing
  function automatic logic [N-1:0] w1(input logic hit,
                                      input logic [31:0] d);
    return hit ? d[N-1:0] : {N{1'b0}};
  endfunction : w1

  // next state: set beats clear in the same cycle
  always_comb begin
    st_next = st_reg;
    st_next.evt = (st_reg.evt & ~w1(bus.wr && bus.addr == EV_CLR,
                   bus.wdata)) | ctx_irq
                  | w1(bus.wr && bus.addr == EV_SET, bus.wdata);
    st_next.msk = (st_reg.msk & ~w1(bus.wr && bus.addr == MK_CLR,
                   bus.wdata))
                  | w1(bus.wr && bus.addr == MK_SET, bus.wdata);
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign evt = st_reg.evt;
  assign msk = st_reg.msk;
  // summary is or of unmasked events
  assign summary = |(st_reg.evt & st_reg.msk);

  // a request is never lost, even under a clear
  a_event_set_wins: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (|ctx_irq) |=> ((evt & $past(ctx_irq)) == $past(ctx_irq)))
    else $error("context event lost");
  // a mask set write leaves those bits set
  a_mask_set_port: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (bus.wr && bus.addr == MK_SET)
    |=> ((msk & $past(bus.wdata[N-1:0])) == $past(bus.wdata[N-1:0])))
    else $error("mask set write not taken");
endmodule : icia_event_bank

/* File: rtl/icia_ctx_bank.sv */
`timescale 1ns/1ps
// context control and descriptor pointer registers, one direction
module icia_ctx_bank #(
  parameter int N = 8,
  parameter logic [11:0] BASE = 12'h200,
  parameter bit IS_RX = 1'b0
) (
  // clock and reset
  input logic clk_sys,
  input logic rst_n,
  // register writes and read decode
  icia_bus_if.bank bus,
  input logic [11:0] rd_addr,
  output logic rd_hit,
  output logic [31:0] rd_data,
  // cycle timer
  input logic [14:0] cycle_now,
  input logic incons,
  // dma engine status
  input logic [N-1:0] dma_active,
  input logic [N-1:0] dma_dead,
  input logic [N-1:0] evt_we,
  input logic [N*5-1:0] evt_code,
  // engine controls, all from flops
  output logic [N-1:0] run_gate,
  output logic [N-1:0] start_pulse,
  output logic [N-1:0] wake_pulse
);
  localparam int CME_BIT =
    IS_RX ? icia_pkg::CTL_CME_RX_BIT : icia_pkg::CTL_CME_TX_BIT;

  typedef struct packed {
    logic [N-1:0] run;
    logic [N-1:0] wake;
    logic [N-1:0] dead;
    logic [N-1:0] act;
    logic [N-1:0] cme;   // waiting for start cycle
    logic [N-1:0] gate;  // engine may proceed
    logic [N-1:0] go;    // start cycle reached
    logic [N-1:0] wk;    // wake handed to engine
    logic [N-1:0][14:0] match;
    logic [N-1:0][4:0] evc;
    logic [N-1:0][31:0] cptr;
  } icia_ctx_state_t;

  icia_ctx_state_t st_reg;
  icia_ctx_state_t st_next;
  logic [11:0] off;
  logic [11:0] roff;

  assign off = bus.addr - BASE;
  assign roff = rd_addr - BASE;

  // slot hit test shared by write and read decode
  function automatic logic in_bank(input logic [11:0] a,
                                   input logic [11:0] o);
    return (a >= BASE) && (o[11:4] < 8'(N));
  endfunction : in_bank

  // control fields, set and clear ports
  always_comb begin
    logic s;
    logic c;
    logic [31:0] d;
    s = 1'b0;
    c = 1'b0;
    d = bus.wdata;
    st_next = st_reg;
    for (int i = 0; i < N; i++) begin
      s = bus.wr && in_bank(bus.addr, off) && off[11:4] == 8'(i)
          && off[3:0] == icia_pkg::CTX_SUB_SET;
      c = bus.wr && in_bank(bus.addr, off) && off[11:4] == 8'(i)
          && off[3:0] == icia_pkg::CTX_SUB_CLR;
      // software run and start-on-cycle control
      if (s) begin
        st_next.run[i] = st_reg.run[i] | d[icia_pkg::CTL_RUN_BIT];
        st_next.cme[i] = st_reg.cme[i] | d[CME_BIT];
        if (!IS_RX) begin
          st_next.match[i] = d[icia_pkg::CTL_MATCH_LSB +:
                               icia_pkg::CTL_MATCH_W];
        end
      end else if (c) begin
        st_next.run[i] = st_reg.run[i] & ~d[icia_pkg::CTL_RUN_BIT];
        st_next.cme[i] = st_reg.cme[i] & ~d[CME_BIT];
        if (!IS_RX) begin
          st_next.match[i] = st_reg.match[i] & ~d[icia_pkg::CTL_MATCH_LSB
                               +: icia_pkg::CTL_MATCH_W];
        end
      end
      // wake lives one cycle, then goes to the engine
      st_next.wake[i] = s & d[icia_pkg::CTL_WAKE_BIT];
      st_next.wk[i] = st_reg.wake[i];
      // dead clears with run, engine report wins
      if (c && d[icia_pkg::CTL_RUN_BIT]) begin
        st_next.dead[i] = 1'b0;
      end
      if (dma_dead[i]) begin
        st_next.dead[i] = 1'b1;
      end
      // five-bit event code from the engine
      if (evt_we[i]) begin
        st_next.evc[i] = evt_code[i*5 +: icia_pkg::CTL_EVT_W];
      end
      if (bus.wr && in_bank(bus.addr, off) && off[11:4] == 8'(i)
          && off[3:0] == icia_pkg::CTX_SUB_CPTR) begin
        st_next.cptr[i] = d;
      end
      // no start on cycle while mismatch pending
      st_next.go[i] = 1'b0;
      if (st_reg.run[i] && st_reg.cme[i] && !incons
          && cycle_now == st_reg.match[i]) begin
        // a set write in the same cycle re-arms the wait
        st_next.cme[i] = s & d[CME_BIT];
        st_next.go[i] = 1'b1;
      end
      st_next.act[i] = dma_active[i] & ~(st_reg.cme[i] & incons);
      st_next.gate[i] = st_next.run[i] & ~st_next.dead[i]
                        & ~st_next.cme[i];
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // read view of the addressed slot
  always_comb begin
    rd_data = '0;
    rd_hit = in_bank(rd_addr, roff);
    for (int i = 0; i < N; i++) begin
      if (rd_hit && roff[11:4] == 8'(i)) begin
        if (roff[3:0] == icia_pkg::CTX_SUB_CPTR) begin
          rd_data = st_reg.cptr[i];
        end else begin
          rd_data[CME_BIT] = st_reg.cme[i];
          if (!IS_RX) begin
            rd_data[icia_pkg::CTL_MATCH_LSB +: icia_pkg::CTL_MATCH_W] =
              st_reg.match[i];
          end
          rd_data[icia_pkg::CTL_RUN_BIT] = st_reg.run[i];
          rd_data[icia_pkg::CTL_WAKE_BIT] = st_reg.wake[i];
          rd_data[icia_pkg::CTL_DEAD_BIT] = st_reg.dead[i];
          rd_data[icia_pkg::CTL_ACTIVE_BIT] = st_reg.act[i];
          rd_data[icia_pkg::CTL_EVT_W-1:0] = st_reg.evc[i];
        end
      end
    end
  end

  assign run_gate = st_reg.gate;
  assign start_pulse = st_reg.go;
  assign wake_pulse = st_reg.wk;

  // a waiting context never starts under a mismatch
  a_cme_held_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    incons |=> ((start_pulse & $past(st_reg.cme)) == '0))
    else $error("start on cycle during mismatch");
  // a waiting context is never granted the engine
  a_cme_no_gate: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ((run_gate & st_reg.cme) == '0))
    else $error("gate open while waiting for cycle");
endmodule : icia_ctx_bank

/* File: tb/icia_iso_ctx_irq_bench.sv */
`timescale 1ns/1ps
module icia_iso_ctx_irq_bench;
  // clock, reset and host port
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  // engine side stimulus and results
  logic [7:0] it_irq = 8'h00;
  logic [7:0] ir_irq = 8'h00;
  logic [7:0] it_act = 8'h00;
  logic [7:0] it_we = 8'h00;
  logic [39:0] it_code = 40'h00_0000_0000;
  logic [14:0] cycle_now = 15'h0000;
  logic incons = 1'b0;
  logic [7:0] it_start;
  logic [7:0] it_gate;
  logic [7:0] it_dead = 8'h00;
  logic [7:0] it_wk;
  logic [7:0] ir_wk;
  logic [7:0] ir_gate;
  logic [7:0] ir_go;
  logic xsum;
  logic rsum;
  logic mism;
  // bookkeeping
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] d;
  logic seen;

  // receive engine status stays quiet; its requests and its wake, gate and start outputs are exercised
  icia_iso_ctx_irq DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .it_irq_req(it_irq), .it_dma_active(it_act), .it_dma_dead(it_dead),
    .it_evt_we(it_we), .it_evt_code(it_code), .it_run_gate(it_gate),
    .it_start(it_start), .it_wake(it_wk),
    .ir_irq_req(ir_irq), .ir_dma_active(8'h00), .ir_dma_dead(8'h00),
    .ir_evt_we(8'h00), .ir_evt_code(40'h00_0000_0000), .ir_run_gate(ir_gate),
    .ir_start(ir_go), .ir_wake(ir_wk), .cycle_now(cycle_now),
    .cycle_incons_pulse(incons), .xmit_summary_bit(xsum),
    .recv_summary_bit(rsum), .cycle_timer_mismatch_event(mism));

  // 100 ns period
  initial forever #50 clk_sys = ~clk_sys;

  // hang guard, far above the hundred-odd cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk

  // settle just past an edge so registered outputs are stable
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // answer stands just after the taking edge, one cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    chk({31'h0, reg_rvalid}, 32'h1);
  endtask : rd

  // all-ones mask shows only the eight implemented contexts
  task automatic t_mask;
    wr(icia_pkg::OFS_ITMSK_SET, 32'hffff_ffff);
    rd(icia_pkg::OFS_ITMSK_SET, d);
    chk(d, 32'h0000_00ff);
    wr(icia_pkg::OFS_IRMSK_SET, 32'hffff_ffff);
    rd(icia_pkg::OFS_IRMSK_CLR, d);
    chk(d, 32'h0000_00ff);
  endtask : t_mask

  // transmit event, summary, masking and sticky clear
  task automatic t_tx;
    @(posedge clk_sys);
    it_irq <= 8'h04;
    @(posedge clk_sys);
    it_irq <= 8'h00;
    tick(1);
    chk({31'h0, xsum}, 32'h1);
    rd(icia_pkg::OFS_ITEV_SET, d);
    chk(d, 32'h0000_0004);
    rd(icia_pkg::OFS_IEV_SET, d);
    chk({30'h0, d[7:6]}, 32'h1);
    wr(icia_pkg::OFS_ITMSK_CLR, 32'h0000_0004);
    tick(2);
    chk({31'h0, xsum}, 32'h0);
    rd(icia_pkg::OFS_ITEV_SET, d);
    chk(d, 32'h0000_0004);
    wr(icia_pkg::OFS_ITMSK_SET, 32'h0000_0004);
    wr(icia_pkg::OFS_ITEV_CLR, 32'h0000_00fb);
    rd(icia_pkg::OFS_ITEV_CLR, d);
    chk(d, 32'h0000_0004);
    wr(icia_pkg::OFS_ITEV_CLR, 32'h0000_0004);
    rd(icia_pkg::OFS_ITEV_SET, d);
    chk(d, 32'h0000_0000);
    tick(2);
    chk({31'h0, xsum}, 32'h0);
  endtask : t_tx

  // receive contexts at both ends of the range
  task automatic t_rx;
    @(posedge clk_sys);
    ir_irq <= 8'h81;
    @(posedge clk_sys);
    ir_irq <= 8'h00;
    tick(1);
    chk({31'h0, rsum}, 32'h1);
    rd(icia_pkg::OFS_IREV_CLR, d);
    chk(d, 32'h0000_0081);
    wr(icia_pkg::OFS_IREV_CLR, 32'h0000_0081);
    rd(icia_pkg::OFS_IREV_SET, d);
    chk(d, 32'h0000_0000);
  endtask : t_rx

  // start-on-cycle held off while the mismatch is pending
  task automatic t_incons;
    wr(12'h200, 32'h8005_8000);
    wr(12'h210, 32'h0000_8000);
    @(posedge clk_sys);
    // context 0's engine claims active, the mismatch must hide it
    it_act <= 8'h03;
    incons <= 1'b1;
    @(posedge clk_sys);
    incons <= 1'b0;
    cycle_now <= 15'h0005;
    seen = 1'b0;
    repeat (6) begin
      tick(1);
      seen = seen | it_start[0];
    end
    chk({31'h0, mism}, 32'h1);
    chk({31'h0, seen}, 32'h0);
    chk({31'h0, it_gate[1]}, 32'h1);
    rd(12'h210, d);
    chk({31'h0, d[10]}, 32'h1);
    // stop the waiting context before clearing, per the re-arm order
    // stop then clear
    wr(12'h204, 32'h0000_8000);
    rd(12'h200, d);
    chk({31'h0, d[10]}, 32'h0);
    wr(icia_pkg::OFS_IEV_CLR, 32'h0080_0000);
    tick(1);
    chk({31'h0, mism}, 32'h0);
    tick(2);
    wr(12'h200, 32'h8005_8000);
    seen = 1'b0;
    repeat (6) begin
      tick(1);
      seen = seen | it_start[0];
    end
    chk({31'h0, seen}, 32'h1);
  endtask : t_incons

  // event code load on context 1, pointer and set/clear on the last context
  task automatic t_ctx;
    @(posedge clk_sys);
    it_code[9:5] <= 5'h1b;
    it_we <= 8'h02;
    it_dead <= 8'h02;
    @(posedge clk_sys);
    it_we <= 8'h00;
    it_dead <= 8'h00;
    rd(12'h210, d);
    chk({27'h0, d[4:0]}, 32'h0000_001b);
    chk({30'h0, d[11], it_gate[1]}, 32'h2);
    wr(12'h27c, 32'h1234_5670);
    rd(12'h27c, d);
    chk(d, 32'h1234_5670);
    wr(12'h270, 32'h0000_8000);
    wr(12'h274, 32'h0000_0000);
    rd(12'h270, d);
    chk({31'h0, d[15]}, 32'h1);
    wr(12'h274, 32'h0000_8000);
    rd(12'h270, d);
    chk({31'h0, d[15]}, 32'h0);
    // wake reaches the engine one edge after the write
    wr(12'h270, 32'h0000_1000);
    tick(1);
    chk({16'h0, it_wk, ir_wk}, 32'h0000_8000);
    wr(12'h410, 32'h0000_1000);
    tick(1);
    chk({16'h0, it_wk, ir_wk}, 32'h0000_0002);
    // receive context waits for its start cycle, then runs
    wr(12'h400, 32'h2000_8000);
    tick(1);
    chk({31'h0, ir_gate[0]}, 32'h0);
    @(posedge clk_sys);
    cycle_now <= 15'h0000;
    tick(1);
    chk({30'h0, ir_go[0], ir_gate[0]}, 32'h3);
  endtask : t_ctx

  task automatic end_of_test;
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // reset for four cycles, then each scenario in turn
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_mask();
    t_tx();
    t_rx();
    t_incons();
    t_ctx();
    end_of_test();
  end
endmodule : icia_iso_ctx_irq_bench
